/* design/io_decode_consts.svh */
`ifndef IO_DECODE_CONSTS_SVH
`define IO_DECODE_CONSTS_SVH
// Instruction class and field positions (bit 0 is the MSB of the word)
`define IO_CLASS_PATTERN 3'h3
`define CPU_DEV_CODE     6'h3F
`define DISC_DEV_CODE    6'h28
`define OP_NO_TRANSFER   3'h0
`define OP_INPUT_A       3'h1
`define OP_OUTPUT_A      3'h2
`define OP_INPUT_B       3'h3
`define OP_OUTPUT_B      3'h4
`define OP_INPUT_C       3'h5
`define OP_OUTPUT_C      3'h6
`define OP_SKIP          3'h7
`define CTRL_NONE        2'h0
`define CTRL_START       2'h1
`define CTRL_CLEAR       2'h2
`define CTRL_PULSE       2'h3
// Avalon register byte offsets
`define REG_INSTR        4'h0
`define REG_ACC0         4'h4
`define REG_ACC1         4'h8
`define REG_ACC2         4'hC
`define REG_STATUS_LO    2'h0
// Reset values
`define PTR_RESET        16'h0000
`endif

/* design/io_decode_pkg.sv */
package io_decode_pkg;
  // Decoded instruction fields
  typedef struct packed {
    logic [1:0] acc;
    logic [2:0] opcode;
    logic [1:0] ctrl;
    logic [5:0] dev;
  } io_fields_t;
  // Transfer request on the I/O bus
  typedef struct packed {
    logic        input_strobe;
    logic        output_strobe;
    logic        pulse_strobe;
    logic [5:0]  dev;
    logic [1:0]  reg_sel;
    logic [15:0] data;
  } io_bus_req_t;
  // Executer state
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_exec  = 4'b0010,
    st_wait  = 4'b0100,
    st_done  = 4'b1000
  } exec_state_t;
endpackage

/* design/io_instruction_decode_cpu_ctl.sv */
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`include "io_decode_consts.svh"
// Notes on behaviour
// - Bits 0-2 equal 011 means I/O class
// - Bits 3-4 pick accumulator; ignored without data
// - Device code bits 10-15 driven onto select
// - Codes 00-76 peripherals; 77 is the CPU
// - Opcode 000 none, 001 input, 010 output
// - Input reads status if even, data if odd
// - Output writes command if even, data if odd
// - Control bits ignored on peripheral transfers
// - Valid codes: serial, expansion, floppy, disc, tape
// - Disc pointer write: zero stops, nonzero starts DMA
// - Start on CPU sets flag, one-instruction delay
// - Clear on CPU clears interrupt-on flag
// - Mask-out above 1: LSB sets or clears all mask bits
// - Mask-out 1 disables DMA, 0 enables
// - I/O reset clears flags, pending, DMA, mask
// - I/O reset pulses peripheral board reset line
// - Output C on CPU enters panel monitor
// - Busy is interrupt-on, done is power fail
// - Power fail interrupts when interrupt-on set
// - Control field picks block pointer on B ops
// - Input B returns the stored pointer unchanged
// - Disc pointer zero stops disc DMA
// - Opcode 111 skips on flag tests
module io_instruction_decode_cpu_ctl
  import io_decode_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // I/O bus
  output logic [5:0]       dev_select,
  output logic             bus_input_strobe,
  output logic             bus_output_strobe,
  output logic [1:0]       bus_reg_sel,
  output logic [15:0]      bus_data_out,
  input  wire logic [15:0] bus_data_in,
  input  wire logic        bus_ack,
  // Processor side
  input  wire logic        power_fail,
  input  wire logic        instr_done_tick,
  output logic             interrupt_request,
  output logic             peripheral_board_reset_pulse,
  output logic             panel_monitor_enter,
  output logic             skip_next,
  output logic             dma_enable,
  output logic             interrupt_mask_state
);

  // Decoded instruction
  io_fields_t  f;
  exec_state_t state;
  logic [15:0] instr;               // Latched instruction word
  logic [15:0] acc [0:3];           // Accumulators
  logic [15:0] mux_ptr;             // Multiplexer block pointer
  logic [15:0] disc_ptr;            // Disc block pointer
  logic [15:0] tape_ptr;            // Tape or floppy block pointer
  logic        interrupt_on_flag;   // Interrupt-on state
  logic        intr_on_arm;         // Pending enable after one instr
  logic        is_io;               // Instruction is I/O class
  logic        is_cpu;              // Device code is processor
  logic        bus_op;              // Peripheral transfer needed
  logic        wr_take;             // Write accepted this edge

  // Field split, bit 0 is the word MSB
  // class check on top three bits
  assign is_io  = (instr[15:13] == `IO_CLASS_PATTERN);
  // Fields in order: acc, opcode, ctrl, device code
  assign f      = instr[12:0];
  // code 77 routes to internal control
  assign is_cpu = (f.dev == `CPU_DEV_CODE);
  // only input and output touch the bus
  // only non-processor codes go to the bus
  assign bus_op = !is_cpu && ((f.opcode == `OP_INPUT_A) ||
                              (f.opcode == `OP_OUTPUT_A));

  // Register select: even code status/command, odd data
  function automatic logic [1:0] reg_select(input logic [5:0] d);
    reg_select = d[0] ? 2'h1 : 2'h0;
  endfunction

  // Pointer by control code
  function automatic logic [15:0] ptr_pick(input logic [1:0] c,
    input logic [15:0] m, input logic [15:0] d, input logic [15:0] t);
    case (c)
      `CTRL_START: ptr_pick = m;
      `CTRL_CLEAR: ptr_pick = d;
      `CTRL_PULSE: ptr_pick = t;
      default:     ptr_pick = 16'h0000;
    endcase
  endfunction

  // Bus slave handshake: waitrequest is a flop, so every request
  // waits one edge; reads capture there, writes act at the next edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Write accepted at the edge where waitrequest is seen low
  assign wr_take = avs_write && !avs_waitrequest;

  // Read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      // Capture at the waiting edge so data stand once it drops
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `REG_INSTR: avs_readdata <= {12'h000, state, instr};
          `REG_ACC0:  avs_readdata <= {16'h0000, acc[0]};
          `REG_ACC1:  avs_readdata <= {16'h0000, acc[1]};
          `REG_ACC2:  avs_readdata <= {interrupt_on_flag, power_fail,
                                       dma_enable, interrupt_mask_state,
                                       12'h000, acc[2]};
          default:    avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Executer state machine, one instruction per write to REG_INSTR
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      instr <= 16'h0000;
    end else begin
      case (state)
        st_idle: begin
          if (wr_take && avs_address == `REG_INSTR) begin
            instr <= avs_writedata[15:0];
            state <= st_exec;
          end
        end
        st_exec: state <= (is_io && bus_op) ? st_wait : st_done;
        st_wait: if (bus_ack) state <= st_done;
        st_done: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // I/O bus drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_select        <= 6'h00;
      bus_input_strobe  <= 1'b0;
      bus_output_strobe <= 1'b0;
      bus_reg_sel       <= 2'h0;
      bus_data_out      <= 16'h0000;
    end else if (state == st_exec && is_io && bus_op) begin
      dev_select        <= f.dev;
      // control field plays no part here
      bus_input_strobe  <= (f.opcode == `OP_INPUT_A);
      bus_output_strobe <= (f.opcode == `OP_OUTPUT_A);
      // even status, odd data on input
      // even command, odd data on output
      bus_reg_sel       <= reg_select(f.dev);
      bus_data_out      <= acc[f.acc];
    end else if (state == st_wait && bus_ack) begin
      bus_input_strobe  <= 1'b0;
      bus_output_strobe <= 1'b0;
    end
  end

  // Accumulators: software loads, input transfers write back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc[0] <= 16'h0000;
      acc[1] <= 16'h0000;
      acc[2] <= 16'h0000;
      acc[3] <= 16'h0000;
    end else if (state == st_idle && wr_take &&
                 avs_address != `REG_INSTR) begin
      acc[avs_address[3:2]] <= avs_writedata[15:0];
    end else if (state == st_wait && bus_ack && bus_input_strobe) begin
      acc[f.acc] <= bus_data_in;
    end else if (state == st_exec && is_io && is_cpu &&
                 f.opcode == `OP_INPUT_B) begin
      // pointer read back unchanged
      acc[f.acc] <= ptr_pick(f.ctrl, mux_ptr, disc_ptr, tape_ptr);
    end
  end

  // Block pointers, loaded by output B
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_ptr  <= `PTR_RESET;
      disc_ptr <= `PTR_RESET;
      tape_ptr <= `PTR_RESET;
    end else if (state == st_exec && is_io && is_cpu &&
                 f.opcode == `OP_OUTPUT_B) begin
      case (f.ctrl)
        `CTRL_START: mux_ptr  <= acc[f.acc];
        // zero value also stops disc DMA in disc_dma_active
        `CTRL_CLEAR: disc_ptr <= acc[f.acc];
        `CTRL_PULSE: tape_ptr <= acc[f.acc];
        default:     ;
      endcase
    end
  end

  // Disc DMA activity follows the disc pointer
  logic disc_dma_active;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disc_dma_active <= 1'b0;
    end else if (state == st_exec && is_io && is_cpu &&
                 f.opcode == `OP_OUTPUT_B && f.ctrl == `CTRL_CLEAR) begin
      disc_dma_active <= (acc[f.acc] != 16'h0000);
    end else if (state == st_exec && is_io && is_cpu &&
                 f.opcode == `OP_INPUT_C && f.ctrl == `CTRL_CLEAR) begin
      disc_dma_active <= 1'b0;
    end
  end

  // Interrupt-on flag and arming; start and clear ops take priority
  // over a same-cycle tick, any other op lets the tick through
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_on_flag <= 1'b0;
      intr_on_arm       <= 1'b0;
    end else if (state == st_exec && is_io && is_cpu &&
                 f.opcode == `OP_NO_TRANSFER && f.ctrl == `CTRL_START) begin
      intr_on_arm <= 1'b1;
    end else if (state == st_exec && is_io && is_cpu &&
                 f.ctrl == `CTRL_CLEAR &&
                 (f.opcode == `OP_NO_TRANSFER ||
                  f.opcode == `OP_INPUT_C)) begin
      interrupt_on_flag <= 1'b0;
      intr_on_arm       <= 1'b0;
    end else if (intr_on_arm && instr_done_tick) begin
      interrupt_on_flag <= 1'b1;
      intr_on_arm       <= 1'b0;
    end
  end

  // Mask, DMA enable and reset pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_mask_state         <= 1'b0;
      dma_enable                   <= 1'b0;
      peripheral_board_reset_pulse <= 1'b0;
    end else begin
      peripheral_board_reset_pulse <= 1'b0;
      if (state == st_exec && is_io && is_cpu) begin
        if (f.opcode == `OP_OUTPUT_B && f.ctrl == `CTRL_NONE) begin
          if (acc[f.acc] > 16'h0001) begin
            // LSB selects mask all or none
            interrupt_mask_state <= acc[f.acc][0];
          end else begin
            // value 0 enables, 1 disables DMA
            dma_enable <= !acc[f.acc][0];
          end
        end else if (f.opcode == `OP_INPUT_C &&
                     f.ctrl == `CTRL_CLEAR) begin
          interrupt_mask_state         <= 1'b0;
          dma_enable                   <= 1'b0;
          peripheral_board_reset_pulse <= 1'b1;
        end
      end
    end
  end

  // Panel monitor entry and skip result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panel_monitor_enter <= 1'b0;
      skip_next           <= 1'b0;
    end else begin
      panel_monitor_enter <= 1'b0;
      if (state == st_exec && is_io && is_cpu) begin
        // output C transfers to the monitor
        panel_monitor_enter <= (f.opcode == `OP_OUTPUT_C);
        if (f.opcode == `OP_SKIP) begin
          // busy is interrupt-on, done is power fail
          case (f.ctrl)
            2'h0:    skip_next <= interrupt_on_flag;
            2'h1:    skip_next <= !interrupt_on_flag;
            2'h2:    skip_next <= power_fail;
            default: skip_next <= !power_fail;
          endcase
        end else begin
          skip_next <= 1'b0;
        end
      end
    end
  end

  // Power fail interrupt request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_request <= 1'b0;
    end else begin
      interrupt_request <= power_fail && interrupt_on_flag;
    end
  end

  // request follows power fail with interrupts on
  a_pf_request: assert property (
    @(posedge clk) disable iff (rst)
    (power_fail && interrupt_on_flag) |=> interrupt_request)
    else $error("power fail did not request interrupt");

  // board reset pulse lasts one cycle
  a_reset_pulse_len: assert property (
    @(posedge clk) disable iff (rst)
    peripheral_board_reset_pulse |=> !peripheral_board_reset_pulse)
    else $error("board reset pulse too long");

  // start does not set the flag at once
  a_intr_on_delay: assert property (
    @(posedge clk) disable iff (rst)
    (state == st_exec && is_io && is_cpu && f.opcode == 3'h0 &&
     f.ctrl == 2'h1 && !interrupt_on_flag) |=> !interrupt_on_flag)
    else $error("interrupt-on set without delay");

  // select lines follow device code on transfer
  a_dev_select: assert property (
    @(posedge clk) disable iff (rst)
    (state == st_exec && is_io && bus_op) |=> dev_select == f.dev)
    else $error("device select mismatch");

  a_reg_parity: assert property (
    @(posedge clk) disable iff (rst)
    (bus_input_strobe || bus_output_strobe) |->
      bus_reg_sel == {1'b0, dev_select[0]})
    else $error("register select parity wrong");

  // disc pointer zero leaves DMA off
  a_disc_zero: assert property (
    @(posedge clk) disable iff (rst)
    (state == st_exec && is_io && is_cpu && f.opcode == 3'h4 &&
     f.ctrl == 2'h2 && acc[f.acc] == 16'h0000) |=> !disc_dma_active)
    else $error("zero disc pointer started DMA");

  // io reset clears mask and DMA
  a_ioreset_clear: assert property (
    @(posedge clk) disable iff (rst)
    $rose(peripheral_board_reset_pulse) |->
      !dma_enable && !interrupt_mask_state && !interrupt_on_flag)
    else $error("io reset left state set");

  // peripheral transfers never touch CPU flags
  a_periph_noflag: assert property (
    @(posedge clk) disable iff (rst)
    (state == st_exec && is_io && bus_op) |=>
      $stable(dma_enable) && $stable(interrupt_mask_state))
    else $error("peripheral op changed CPU flags");

  // panel entry is a single pulse
  a_panel_pulse: assert property (
    @(posedge clk) disable iff (rst)
    panel_monitor_enter |=> !panel_monitor_enter)
    else $error("panel entry pulse too long");

endmodule

/* tb/io_peripheral_model.sv */
module io_peripheral_model #(
  parameter logic [5:0]  MY_CODE     = 6'h08,
  parameter logic [15:0] STATUS_INIT = 16'h5A3C,
  parameter logic [15:0] DATA_INIT   = 16'h0F0F,
  parameter int          DELAY       = 0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus from the decoder
  input  wire logic [5:0]  dev_select,
  input  wire logic        bus_input_strobe,
  input  wire logic        bus_output_strobe,
  input  wire logic [15:0] bus_data_out,
  // Answer to the decoder
  output logic [15:0]      data_in,
  output logic             ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] data_reg;  // Data register
  logic [15:0] cmd_reg;   // Command register
  logic [15:0] last;      // Last value shown on the data lines
  logic [3:0]  wait_cnt;  // Answer delay counter
  logic        sel;       // Own code seen with a strobe
  assign sel = (dev_select == MY_CODE)
               && (bus_input_strobe || bus_output_strobe);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack      <= 1'b0;
      wait_cnt <= 4'h0;
      data_reg <= DATA_INIT;
      cmd_reg  <= 16'h0000;
      last     <= 16'h0000;
    end else if (!sel) begin
      ack      <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!ack && wait_cnt == 4'(DELAY)) begin
      ack  <= 1'b1;
      last <= MY_CODE[0] ? data_reg : STATUS_INIT;
      if (bus_output_strobe && MY_CODE[0]) data_reg <= bus_data_out;
      if (bus_output_strobe && !MY_CODE[0]) cmd_reg <= bus_data_out;
    end else if (!ack) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // Released lines show the inverse of the last value
  assign data_in = ack ? last : ~last;
endmodule

/* tb/io_instruction_decode_cpu_ctl_test.sv */
`include "io_decode_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module io_instruction_decode_cpu_ctl_test;
  import io_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic [5:0]  dev_select, last_dev;
  logic bus_input_strobe, bus_output_strobe, bus_ack, ack_a, ack_b;
  logic [1:0]  bus_reg_sel, last_sel;
  logic [15:0] bus_data_out, bus_data_in, d_a, d_b;
  logic power_fail = 0, instr_done_tick = 0, interrupt_request, skip_next;
  logic peripheral_board_reset_pulse, panel_monitor_enter;
  logic dma_enable, interrupt_mask_state, last_out;
  int errors = 0, checked = 0, n_strb = 0, n_pan = 0, n_brst = 0, k;
  localparam logic [5:0] CPU = `CPU_DEV_CODE;
  localparam logic [3:0] ADDR_C = 4'hC;
  // Clock
  always #5 clk = ~clk;
  io_instruction_decode_cpu_ctl i_io_instruction_decode_cpu_ctl (.clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .dev_select, .bus_input_strobe, .bus_output_strobe,
    .bus_reg_sel, .bus_data_out, .bus_data_in, .bus_ack, .power_fail,
    .instr_done_tick, .interrupt_request, .peripheral_board_reset_pulse,
    .panel_monitor_enter, .skip_next, .dma_enable, .interrupt_mask_state);
  // devices sit on valid codes, never 00
  io_peripheral_model #(.MY_CODE(6'h08), .DELAY(0)) i_dev_a (.clk, .rst,
    .dev_select, .bus_input_strobe, .bus_output_strobe, .bus_data_out,
    .data_in(d_a), .ack(ack_a));
  io_peripheral_model #(.MY_CODE(6'h09), .DELAY(3)) i_dev_b (.clk, .rst,
    .dev_select, .bus_input_strobe, .bus_output_strobe, .bus_data_out,
    .data_in(d_b), .ack(ack_b));
  // Two answering devices share the bus
  assign bus_ack = ack_a | ack_b;
  assign bus_data_in = ack_a ? d_a : d_b;
  // Bus and pulse watcher
  always @(posedge clk) begin
    if (bus_input_strobe === 1'b1 || bus_output_strobe === 1'b1) begin
      n_strb++;
      last_dev = dev_select;
      last_sel = bus_reg_sel;
      last_out = bus_output_strobe;
    end
    if (panel_monitor_enter === 1'b1) n_pan++;
    if (peripheral_board_reset_pulse === 1'b1) n_brst++;
  end
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bus cycle: hold until waitrequest seen low at a rising edge
  task automatic bus_op(input logic rd, input logic [3:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        errors++;
        print_verdict();
      end
    end while (avs_waitrequest !== 1'b0);
    // Read data taken at the accepting edge, then one idle edge
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] ins(input logic [1:0] a,
      input logic [2:0] o, input logic [1:0] c, input logic [5:0] d);
    return {`IO_CLASS_PATTERN, a, o, c, d};
  endfunction
  task automatic run(input logic [15:0] w);
    bus_op(1'b0, `REG_INSTR, {16'h0000, w});
    repeat (10) @(posedge clk);
  endtask
  task automatic acc1(input logic [15:0] v);
    bus_op(1'b0, `REG_ACC0, {16'h0000, v});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_op(1'b0, ADDR_C, 32'h0000_00C5);
    acc1(16'h1234);
    run(ins(2'h3, `OP_OUTPUT_A, `CTRL_PULSE, 6'h08));
    `CHK("cmd_reg", 16'h00C5, i_dev_a.cmd_reg)
    `CHK("dev_sel", 6'h08, last_dev)
    `CHK("reg_sel", 2'h0, last_sel)
    `CHK("out_dir", 1'b1, last_out)
    run(ins(2'h1, `OP_OUTPUT_A, `CTRL_NONE, 6'h09));
    `CHK("data_reg", 16'h1234, i_dev_b.data_reg)
    `CHK("reg_sel", 2'h1, last_sel)
    run(ins(2'h2, `OP_INPUT_A, `CTRL_START, 6'h08));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("acc2 stat", 16'h5A3C, rdat[15:0])
    `CHK("in_dir", 1'b0, last_out)
    run(ins(2'h2, `OP_INPUT_A, `CTRL_NONE, 6'h09));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("acc2 data", 16'h1234, rdat[15:0])
    k = n_strb;
    run({3'h2, 2'h1, `OP_OUTPUT_A, `CTRL_NONE, 6'h08});
    run(ins(2'h1, `OP_INPUT_B, `CTRL_NONE, 6'h08));
    run(ins(2'h1, `OP_NO_TRANSFER, `CTRL_NONE, 6'h08));
    `CHK("no strobe", k, n_strb)
    run(ins(2'h0, `OP_NO_TRANSFER, `CTRL_START, CPU));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("on_flag early", 1'b0, rdat[31])
    instr_done_tick <= 1'b1;
    @(posedge clk);
    instr_done_tick <= 1'b0;
    power_fail <= 1'b1;
    repeat (4) @(posedge clk);
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("on_flag set", 1'b1, rdat[31])
    `CHK("pf flag", 1'b1, rdat[30])
    `CHK("irq", 1'b1, interrupt_request)
    for (int c = 0; c < 4; c++) begin
      run(ins(2'h0, `OP_SKIP, 2'(c), CPU));
      `CHK("skip", ~c[0], skip_next)
    end
    run(ins(2'h0, `OP_NO_TRANSFER, `CTRL_CLEAR, CPU));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("on_flag clr", 1'b0, rdat[31])
    `CHK("irq off", 1'b0, interrupt_request)
    power_fail <= 1'b0;
    for (int v = 3; v >= 0; v--) begin
      acc1(16'(v));
      run(ins(2'h1, `OP_OUTPUT_B, `CTRL_NONE, CPU));
      if (v > 1) `CHK("mask", v[0], interrupt_mask_state)
      else `CHK("dma", ~v[0], dma_enable)
    end
    acc1(16'h0003);
    run(ins(2'h1, `OP_OUTPUT_B, `CTRL_NONE, CPU));
    acc1(16'h0123);
    run(ins(2'h1, `OP_OUTPUT_B, `CTRL_CLEAR, CPU));
    run(ins(2'h2, `OP_INPUT_B, `CTRL_CLEAR, CPU));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("disc ptr", 16'h0123, rdat[15:0])
    run(ins(2'h0, `OP_NO_TRANSFER, `CTRL_START, CPU));
    k = n_brst;
    run(ins(2'h0, `OP_INPUT_C, `CTRL_CLEAR, CPU));
    `CHK("brst", k + 1, n_brst)
    `CHK("dma rst", 1'b0, dma_enable)
    `CHK("mask rst", 1'b0, interrupt_mask_state)
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("on_flag rst", 1'b0, rdat[31])
    run(ins(2'h1, `OP_INPUT_B, `CTRL_CLEAR, CPU));
    bus_op(1'b0, `REG_ACC0, 32'h0);
    run(ins(2'h1, `OP_OUTPUT_B, `CTRL_CLEAR, CPU));
    run(ins(2'h2, `OP_INPUT_B, `CTRL_CLEAR, CPU));
    bus_op(1'b1, ADDR_C, 32'h0);
    `CHK("ptr zero", 16'h0000, rdat[15:0])
    run(ins(2'h0, `OP_OUTPUT_C, `CTRL_NONE, CPU));
    `CHK("panel", 1, n_pan)
    print_verdict();
  end
endmodule
